// [logic/fecr_pkg.sv]
// package: register map, field layout and constants for the flash ecc/option block
//------------------------------------------------------------
// Overview of operation
// - factory test reserved registers read zero and ignore writes
// - captured fault record freezes until software clears its fault flag
// - simultaneous single and double faults record the double fault
// - index 000 gives check bits high, zero bit 7, address upper seven bits
// - index 001 low address; indices 010 to 101 give phrase words
// - indices 110 and 111 read as zero
// - check byte holds eight bits for program array, six for data array
// - program array capture keeps raw uncorrected data and check bits
// - data array fault: 001 low address, 010 single uncorrected word
// - both result window bytes readable, writes have no effect
// - option register loads from nonvolatile option byte during reset sequence
// - double fault on option phrase at reset forces option bits to ones
// - option register is read only to software
// - a write to clock divider register while command complete flag is set sets divider loaded bit
// - divider loaded reads zero from reset until first divider write made while command complete flag is set
// - program or erase launched without divider load fails, sets access error
//------------------------------------------------------------
package fecr_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CLK_DIV    = 5'h00;
  localparam logic [4:0] OFS_STATUS     = 5'h06;
  localparam logic [4:0] OFS_FAULT_FLAG = 5'h07;
  localparam logic [4:0] OFS_INDEX      = 5'h02;
  localparam logic [4:0] OFS_RSV_A      = 5'h0c;
  localparam logic [4:0] OFS_RSV_B      = 5'h0d;
  localparam logic [4:0] OFS_RES_HI     = 5'h0e;
  localparam logic [4:0] OFS_RES_LO     = 5'h0f;
  localparam logic [4:0] OFS_OPTION     = 5'h10;
  localparam logic [4:0] OFS_RSV_C      = 5'h11;
  localparam logic [4:0] OFS_RSV_D      = 5'h12;
  localparam logic [4:0] OFS_RSV_E      = 5'h13;
  localparam logic [4:0] OFS_CMD        = 5'h14;
  // status and clock divider register bit positions
  localparam int BIT_COMMAND_COMPLETE_FLAG   = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PVIOL  = 4;
  localparam int BIT_DIVLD  = 7;
  // fault flag bit positions
  localparam int BIT_DBL = 1;
  localparam int BIT_SGL = 0;
  // index codes
  localparam logic [2:0] IX_PAR_ADDR = 3'h0;
  localparam logic [2:0] IX_ADDR_LO  = 3'h1;
  localparam logic [2:0] IX_DATA0    = 3'h2;
  localparam logic [2:0] IX_DATA1    = 3'h3;
  localparam logic [2:0] IX_DATA2    = 3'h4;
  localparam logic [2:0] IX_DATA3    = 3'h5;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] ONES8       = 8'hff;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [1:0] ZERO2       = 2'b00;
  localparam logic [6:0] DIV_RESET   = 7'h00;
  localparam logic [22:0] OPTION_FAILING_GLOBAL_ADDR_HIGH = 23'h7f_ff0e;
  localparam logic [7:0] CMD_PROG_FIRST = 8'h06;
  localparam logic [7:0] CMD_PROG_LAST  = 8'h12;
  typedef enum logic [1:0] {
    FECR_LD_IDLE = 2'b00,
    FECR_LD_REQ  = 2'b01,
    FECR_LD_DONE = 2'b10
  } fecr_ld_t;
endpackage

// [logic/fecr_capture.sv]
// module: ecc fault capture record and indexed result window
`timescale 1ns/1ps
module fecr_capture
  import fecr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sgl_fault,
  input  wire logic        dbl_fault,
  input  wire logic        fault_is_data_arr,
  input  wire logic [22:0] fault_addr,
  input  wire logic [7:0]  fault_check_bits,
  input  wire logic [63:0] fault_raw_data,
  input  wire logic        clr_sgl,
  input  wire logic        clr_dbl,
  input  wire logic [2:0]  fault_capture_index,
  output logic             sgl_flag,
  output logic             dbl_flag,
  output logic [15:0]      ecc_fault_result
);
  logic [7:0]  captured_check_bits;
  logic [22:0] cap_addr;
  logic [63:0] cap_data;
  logic        armed;
  logic        take;
  logic [7:0]  par_in;

  //------------------------------------------------------------
  // capture
  //------------------------------------------------------------
  // freeze while flagged
  // clearing write re-arms at once, so a fault in that cycle still sets
  assign armed = (!sgl_flag || clr_sgl) && (!dbl_flag || clr_dbl);
  assign take  = armed && (sgl_fault || dbl_fault);
  assign par_in = fault_is_data_arr ? {ZERO2, fault_check_bits[5:0]} : fault_check_bits;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_check_bits <= ZERO8;
      cap_addr            <= 23'h00_0000;
      cap_data            <= 64'h0000_0000_0000_0000;
    end else if (take) begin
      captured_check_bits <= par_in;
      cap_addr            <= fault_addr;
      cap_data            <= fault_is_data_arr ? {48'h0000_0000_0000, fault_raw_data[15:0]}
                                               : fault_raw_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbl_flag <= 1'b0;
      sgl_flag <= 1'b0;
    end else begin
      dbl_flag <= (take && dbl_fault) || (dbl_flag && !clr_dbl);
      sgl_flag <= (take && !dbl_fault) || (sgl_flag && !clr_sgl);
    end
  end

  //------------------------------------------------------------
  // result window
  //------------------------------------------------------------
  // combinational index select
  always_comb begin
    case (fault_capture_index)
      IX_PAR_ADDR: ecc_fault_result = {captured_check_bits, 1'b0, cap_addr[22:16]};
      IX_ADDR_LO:  ecc_fault_result = cap_addr[15:0];
      IX_DATA0:    ecc_fault_result = cap_data[15:0];
      IX_DATA1:    ecc_fault_result = cap_data[31:16];
      IX_DATA2:    ecc_fault_result = cap_data[47:32];
      IX_DATA3:    ecc_fault_result = cap_data[63:48];
      default:     ecc_fault_result = ZERO16;
    endcase
  end

  a_freeze_rec: assert property (@(posedge clk) disable iff (!rst_n)
    !armed |=> $stable(cap_addr))
    else $error("record changed while frozen");
  a_dbl_prio: assert property (@(posedge clk) disable iff (!rst_n)
    (armed && sgl_fault && dbl_fault) |=> (dbl_flag && !sgl_flag))
    else $error("single fault won over double");
  a_unused_ix: assert property (@(posedge clk) disable iff (!rst_n)
    (fault_capture_index[2:1] == 2'b11) |-> (ecc_fault_result == ZERO16))
    else $error("unused index not zero");
  a_data_par: assert property (@(posedge clk) disable iff (!rst_n)
    (take && fault_is_data_arr) |=> (captured_check_bits[7:6] == ZERO2))
    else $error("data array top check bits not zero");
  a_rearm_take: assert property (@(posedge clk) disable iff (!rst_n)
    (armed && dbl_fault) |=> (cap_addr == $past(fault_addr)))
    else $error("rearmed capture missed address");
endmodule

// [logic/fecr_option_load.sv]
// module: reset sequence load of the nonvolatile option byte
`timescale 1ns/1ps
module fecr_option_load
  import fecr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic             nv_rd_req,
  output logic [22:0]      nv_rd_addr,
  input  wire logic        nv_rd_valid,
  input  wire logic [7:0]  nv_rd_data,
  input  wire logic        nv_rd_dbl_fault,
  output logic [7:0]       option_bits,
  output logic             load_done
);
  fecr_ld_t state;
  fecr_ld_t next_state;
  logic [7:0] next_option;

  //------------------------------------------------------------
  // load sequencer
  //------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      FECR_LD_IDLE: next_state = FECR_LD_REQ;
      FECR_LD_REQ:  next_state = nv_rd_valid ? FECR_LD_DONE : FECR_LD_REQ;
      FECR_LD_DONE: next_state = FECR_LD_DONE;
      default:      next_state = FECR_LD_IDLE;
    endcase
  end

  assign next_option = nv_rd_dbl_fault ? ONES8 : nv_rd_data;
  assign nv_rd_req   = (state == FECR_LD_REQ);
  assign nv_rd_addr  = OPTION_FAILING_GLOBAL_ADDR_HIGH;
  assign load_done   = (state == FECR_LD_DONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FECR_LD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // load once, never written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      option_bits <= ZERO8;
    end else if (nv_rd_req && nv_rd_valid) begin
      option_bits <= next_option;
    end
  end

  a_opt_dbl: assert property (@(posedge clk) disable iff (!rst_n)
    (nv_rd_req && nv_rd_valid && nv_rd_dbl_fault) |=> (option_bits == ONES8))
    else $error("option not forced on double fault");
  a_opt_hold: assert property (@(posedge clk) disable iff (!rst_n)
    load_done |=> $stable(option_bits))
    else $error("option changed after load");
endmodule

// [logic/fecr_top.sv]
// module: flash register block with ecc capture, option byte and divider gating
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module fecr_top
  import fecr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        sgl_fault,
  input  wire logic        dbl_fault,
  input  wire logic        fault_is_data_arr,
  input  wire logic [22:0] fault_addr,
  input  wire logic [7:0]  fault_check_bits,
  input  wire logic [63:0] fault_raw_data,
  output logic             nv_rd_req,
  output logic [22:0]      nv_rd_addr,
  input  wire logic        nv_rd_valid,
  input  wire logic [7:0]  nv_rd_data,
  input  wire logic        nv_rd_dbl_fault,
  input  wire logic        pviol_event,
  input  wire logic        cmd_done,
  output logic             cmd_start,
  output logic [7:0]       cmd_code,
  output logic [6:0]       divide_ratio,
  output logic             divider_loaded,
  output logic [7:0]       option_bits,
  output logic             option_ready
);
  logic [2:0]  fault_capture_index;
  logic        access_error_flag;
  logic        protection_violation_flag;
  logic        command_complete_flag;
  logic        sgl_flag;
  logic        dbl_flag;
  logic [15:0] ecc_fault_result;
  logic [7:0]  next_rdata;
  logic        wr_div;
  logic        wr_stat;
  logic        wr_flag;
  logic        wr_ix;
  logic        wr_cmd;
  logic        launch;
  logic        is_prog;
  logic        bad_launch;
  logic        clr_sgl;
  logic        clr_dbl;

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_div  = reg_wr && hit(reg_addr, OFS_CLK_DIV);
  assign wr_stat = reg_wr && hit(reg_addr, OFS_STATUS);
  assign wr_flag = reg_wr && hit(reg_addr, OFS_FAULT_FLAG);
  assign wr_ix   = reg_wr && hit(reg_addr, OFS_INDEX);
  assign wr_cmd  = reg_wr && hit(reg_addr, OFS_CMD) && command_complete_flag;
  // launch by writing one to complete flag
  assign launch  = wr_stat && reg_wdata[BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag;
  assign is_prog = (cmd_code >= CMD_PROG_FIRST) && (cmd_code <= CMD_PROG_LAST);
  // refuse program or erase until divider loaded
  assign bad_launch = launch && is_prog && !divider_loaded;
  assign cmd_start  = launch && !bad_launch;
  assign clr_sgl = wr_flag && reg_wdata[BIT_SGL];
  assign clr_dbl = wr_flag && reg_wdata[BIT_DBL];

  //------------------------------------------------------------
  // control registers
  //------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_capture_index <= IX_PAR_ADDR;
      cmd_code            <= ZERO8;
    end else begin
      if (wr_ix) begin
        fault_capture_index <= reg_wdata[2:0];
      end
      if (wr_cmd) begin
        cmd_code <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divide_ratio   <= DIV_RESET;
      divider_loaded <= 1'b0;
    end else if (wr_div && command_complete_flag) begin
      divide_ratio   <= reg_wdata[6:0];
      divider_loaded <= 1'b1;
    end
  end

  // status flags, hardware set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      command_complete_flag     <= 1'b1;
    end else begin
      access_error_flag <= bad_launch ||
                           (access_error_flag && !(wr_stat && reg_wdata[BIT_ACCESS_ERROR_FLAG]));
      protection_violation_flag <= pviol_event ||
                           (protection_violation_flag && !(wr_stat && reg_wdata[BIT_PVIOL]));
      // complete flag cleared by cmd_start (launch not refused), set on done
      command_complete_flag <= cmd_done || (command_complete_flag && !cmd_start);
    end
  end

  //------------------------------------------------------------
  // sub blocks
  //------------------------------------------------------------
  fecr_capture u_capture (
    .clk                 (clk),
    .rst_n               (rst_n),
    .sgl_fault           (sgl_fault),
    .dbl_fault           (dbl_fault),
    .fault_is_data_arr   (fault_is_data_arr),
    .fault_addr          (fault_addr),
    .fault_check_bits    (fault_check_bits),
    .fault_raw_data      (fault_raw_data),
    .clr_sgl             (clr_sgl),
    .clr_dbl             (clr_dbl),
    .fault_capture_index (fault_capture_index),
    .sgl_flag            (sgl_flag),
    .dbl_flag            (dbl_flag),
    .ecc_fault_result    (ecc_fault_result)
  );

  fecr_option_load u_option (
    .clk             (clk),
    .rst_n           (rst_n),
    .nv_rd_req       (nv_rd_req),
    .nv_rd_addr      (nv_rd_addr),
    .nv_rd_valid     (nv_rd_valid),
    .nv_rd_data      (nv_rd_data),
    .nv_rd_dbl_fault (nv_rd_dbl_fault),
    .option_bits     (option_bits),
    .load_done       (option_ready)
  );

  //------------------------------------------------------------
  // read path
  //------------------------------------------------------------
  // reserved zero, read-only windows
  always_comb begin
    case (reg_addr)
      OFS_CLK_DIV:    next_rdata = {divider_loaded, divide_ratio};
      OFS_INDEX:      next_rdata = {5'b00000, fault_capture_index};
      OFS_STATUS:     next_rdata = {command_complete_flag, 1'b0, access_error_flag,
                                    protection_violation_flag, 4'h0};
      OFS_FAULT_FLAG: next_rdata = {6'b000000, dbl_flag, sgl_flag};
      OFS_RES_HI:     next_rdata = ecc_fault_result[15:8];
      OFS_RES_LO:     next_rdata = ecc_fault_result[7:0];
      OFS_OPTION:     next_rdata = option_bits;
      OFS_CMD:        next_rdata = cmd_code;
      default:        next_rdata = ZERO8;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= ZERO8;
    end
  end

  a_rsv_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && (reg_addr == OFS_RSV_A || reg_addr == OFS_RSV_C || reg_addr == OFS_RSV_E))
    |=> (reg_rdata == ZERO8))
    else $error("reserved register read nonzero");
  a_res_hi_rd: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_RES_HI) |=> (reg_rdata == $past(ecc_fault_result[15:8])))
    else $error("result high byte mismatch");
  a_div_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_div && command_complete_flag) |=> divider_loaded)
    else $error("divider write did not set loaded");
  a_div_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (!divider_loaded && !(wr_div && command_complete_flag)) |=> !divider_loaded)
    else $error("loaded bit set without write");
  a_no_div_err: assert property (@(posedge clk) disable iff (!rst_n)
    bad_launch |-> (!cmd_start ##1 access_error_flag))
    else $error("unloaded divider launch not refused");
  a_opt_rd: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_OPTION) |=> (reg_rdata == option_bits))
    else $error("option read mismatch");
endmodule

// [test/tb_fecr_top.sv]
// testbench: self-checking bench for the flash ecc capture, option and divider block
`timescale 1ns/1ps
module tb_fecr_top;
  import fecr_pkg::*;
  //------------------------------------------------------------
  // signals
  //------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        sgl_fault = 1'b0;
  logic        dbl_fault = 1'b0;
  logic        fault_is_data_arr = 1'b0;
  logic [22:0] fault_addr = 23'h00_0000;
  logic [7:0]  fault_check_bits = 8'h00;
  logic [63:0] fault_raw_data = 64'h0000_0000_0000_0000;
  logic        nv_rd_req;
  logic [22:0] nv_rd_addr;
  logic        nv_rd_valid = 1'b0;
  logic [7:0]  nv_rd_data = 8'h00;
  logic        nv_rd_dbl_fault = 1'b0;
  logic        pviol_event = 1'b0;
  logic        cmd_done = 1'b0;
  logic        cmd_start;
  logic [7:0]  cmd_code;
  logic [6:0]  divide_ratio;
  logic        divider_loaded;
  logic [7:0]  option_bits;
  logic        option_ready;
  int          seed = 68;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic        st;
  logic        e_arr;
  logic [22:0] e_addr;
  logic [7:0]  e_cb;
  logic [63:0] e_data;

  fecr_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sgl_fault(sgl_fault),
    .dbl_fault(dbl_fault), .fault_is_data_arr(fault_is_data_arr), .fault_addr(fault_addr),
    .fault_check_bits(fault_check_bits), .fault_raw_data(fault_raw_data),
    .nv_rd_req(nv_rd_req), .nv_rd_addr(nv_rd_addr), .nv_rd_valid(nv_rd_valid),
    .nv_rd_data(nv_rd_data), .nv_rd_dbl_fault(nv_rd_dbl_fault), .pviol_event(pviol_event),
    .cmd_done(cmd_done), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .divide_ratio(divide_ratio), .divider_loaded(divider_loaded),
    .option_bits(option_bits), .option_ready(option_ready));

  always #5 clk = ~clk;

  //------------------------------------------------------------
  // checking and bus tasks
  //------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
    end
    @(negedge clk) st = cmd_start;
    @(posedge clk) reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk) begin
      reg_addr <= a;
      reg_rd <= 1'b1;
    end
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) d = reg_rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    rd(a, d);
    chk8(nm, exp, d);
  endtask

  //------------------------------------------------------------
  // expectations and stimulus helpers
  //------------------------------------------------------------
  function automatic logic [15:0] exp_win(input logic [2:0] ix);
    logic [7:0] cb;
    cb = e_arr ? {2'b00, e_cb[5:0]} : e_cb;
    case (ix)
      3'h0: exp_win = {cb, 1'b0, e_addr[22:16]};
      3'h1: exp_win = e_addr[15:0];
      3'h2: exp_win = e_data[15:0];
      3'h3: exp_win = e_arr ? 16'h0000 : e_data[31:16];
      3'h4: exp_win = e_arr ? 16'h0000 : e_data[47:32];
      3'h5: exp_win = e_arr ? 16'h0000 : e_data[63:48];
      default: exp_win = 16'h0000;
    endcase
  endfunction

  task automatic win_check();
    logic [7:0] h;
    logic [7:0] l;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_INDEX, 8'(i));
      rdchk(OFS_INDEX, 8'(i), "index reg");
      rd(OFS_RES_HI, h);
      rd(OFS_RES_LO, l);
      chk16("window", exp_win(3'(i)), {h, l});
    end
  endtask

  task automatic fault(input logic s, input logic dd, input logic arr, input logic upd);
    logic [22:0] a;
    logic [7:0]  c;
    logic [63:0] w;
    a = 23'($random(seed));
    c = 8'($random(seed));
    w = {$random(seed), $random(seed)};
    if (upd) begin
      e_addr = a;
      e_cb = c;
      e_data = w;
      e_arr = arr;
    end
    @(posedge clk) begin
      sgl_fault <= s;
      dbl_fault <= dd;
      fault_is_data_arr <= arr;
      fault_addr <= a;
      fault_check_bits <= c;
      fault_raw_data <= w;
    end
    @(posedge clk) begin
      sgl_fault <= 1'b0;
      dbl_fault <= 1'b0;
    end
  endtask

  task automatic do_reset(input logic dbl, output logic [7:0] ev);
    int i;
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (nv_rd_req !== 1'b1 && i < 20);
    chk8("nv addr hi", 8'h7f, {1'b0, nv_rd_addr[22:16]});
    chk16("nv addr lo", 16'hff0e, nv_rd_addr[15:0]);
    ev = 8'($random(seed));
    repeat (2) @(posedge clk);
    nv_rd_valid <= 1'b1;
    nv_rd_data <= ev;
    nv_rd_dbl_fault <= dbl;
    @(posedge clk) nv_rd_valid <= 1'b0;
    @(negedge clk);
    if (dbl) begin
      ev = 8'hff;
    end
    chk8("option bits", ev, option_bits);
    chk8("option ready", 8'h01, {7'h00, option_ready});
    chk8("nv req", 8'h00, {7'h00, nv_rd_req});
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    logic [7:0] ov;
    logic [7:0] dv;
    logic [4:0] rsv [6];
    rsv = '{OFS_RSV_A, OFS_RSV_B, OFS_RSV_C, OFS_RSV_D, OFS_RSV_E, 5'h1f};
    do_reset(1'b0, ov);
    wr(OFS_OPTION, ~ov);
    rdchk(OFS_OPTION, ov, "option reg");
    rdchk(OFS_CLK_DIV, 8'h00, "divider reg");
    $display("test option done");
    for (int i = 0; i < 6; i++) begin
      wr(rsv[i], 8'($random(seed)));
      rdchk(rsv[i], 8'h00, "reserved");
    end
    $display("test reserved done");
    wr(OFS_CMD, CMD_PROG_FIRST);
    wr(OFS_STATUS, 8'h80);
    chk8("start", 8'h00, {7'h00, st});
    rdchk(OFS_STATUS, 8'ha0, "status");
    @(posedge clk) pviol_event <= 1'b1;
    @(posedge clk) pviol_event <= 1'b0;
    rdchk(OFS_STATUS, 8'hb0, "status");
    wr(OFS_STATUS, 8'h30);
    rdchk(OFS_STATUS, 8'h80, "status");
    dv = {1'b0, 7'($random(seed))};
    wr(OFS_CLK_DIV, dv);
    rdchk(OFS_CLK_DIV, {1'b1, dv[6:0]}, "divider reg");
    chk8("loaded", 8'h01, {7'h00, divider_loaded});
    chk8("ratio", dv, {1'b0, divide_ratio});
    wr(OFS_CMD, CMD_PROG_LAST);
    wr(OFS_STATUS, 8'h80);
    chk8("start", 8'h01, {7'h00, st});
    chk8("cmd code", CMD_PROG_LAST, cmd_code);
    rdchk(OFS_STATUS, 8'h00, "status");
    wr(OFS_CLK_DIV, ~dv);
    rdchk(OFS_CLK_DIV, {1'b1, dv[6:0]}, "divider reg");
    @(posedge clk) cmd_done <= 1'b1;
    @(posedge clk) cmd_done <= 1'b0;
    rdchk(OFS_STATUS, 8'h80, "status");
    $display("test divider done");
    fault(1'b1, 1'b0, 1'b0, 1'b1);
    rdchk(OFS_FAULT_FLAG, 8'h01, "fault flags");
    win_check();
    fault(1'b0, 1'b1, 1'b0, 1'b0);
    rdchk(OFS_FAULT_FLAG, 8'h01, "fault flags");
    win_check();
    wr(OFS_FAULT_FLAG, 8'h01);
    rdchk(OFS_FAULT_FLAG, 8'h00, "fault flags");
    fault(1'b1, 1'b1, 1'b1, 1'b1);
    rdchk(OFS_FAULT_FLAG, 8'h02, "fault flags");
    wr(OFS_RES_HI, 8'($random(seed)));
    wr(OFS_RES_LO, 8'($random(seed)));
    win_check();
    fork
      wr(OFS_FAULT_FLAG, 8'h02);
      fault(1'b1, 1'b0, 1'b0, 1'b1);
    join
    rdchk(OFS_FAULT_FLAG, 8'h01, "fault flags");
    win_check();
    $display("test capture done");
    // second reset with double fault on option
    do_reset(1'b1, ov);
    rdchk(OFS_OPTION, 8'hff, "option reg");
    rdchk(OFS_CLK_DIV, 8'h00, "divider reg");
    $display("test second reset done");
    report_and_stop();
  end
endmodule
